// >>> hw/clstm_target_map.sv
// closed-loop speed target map: duty command to applied rpm target
//
// Function
// - both flags clear: zero low, hysteresis between
// - keep-running flag: initial speed below begin duty
// - zero-duty flag: full speed or full duty
// - optional breakpoint, second gain above it
// - breakpoint field, twice field over 512
// - breakpoint zero means single gain
// - first gain fourteen bits, 1/64 rpm step
// - second gain fourteen bits, same scale
// - decode begin, halt and top duty thresholds
// - initial speed target twelve bits, 1 rpm
// - full speed derived, never stored
// - breakpoint combines with other options
// - limit falls of target, not rises
// - three-bit drop limit step table
// - mode bit: closed loop zero, open one
// - pass-through at or above top duty
// - nine-bit speed command
`timescale 1ns/1ns
module clstm_target_map #(
	parameter int DROP_INTERVAL_CYCLES = clstm_pkg::CLSTM_DROP_INTERVAL_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire clstm_pkg::clstm_reg_req_t reg_req,
	output logic [7:0] reg_rd_data,
	input wire logic [8:0] speed_command,
	output clstm_pkg::clstm_target_t target
);
	import clstm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// difference that stops at zero instead of wrapping
	// so a span below its threshold counts zero
	function automatic logic [9:0] clstm_sat_sub(input logic [9:0] a, input logic [9:0] b);
		clstm_sat_sub = (a > b) ? a - b : 10'h000;
	endfunction

	// one straight segment: base plus gain times span, gain in 1/64 rpm per step
	// a 24-bit product cannot wrap for these widths
	// the shift truncates each segment separately
	function automatic logic [19:0] clstm_seg(input logic [19:0] base,
		input logic [13:0] gain, input logic [9:0] span);
		logic [23:0] prod;
		prod = {10'h000, gain} * {14'h0000, span};
		clstm_seg = base + {2'b00, prod[23:CLSTM_GAIN_SHIFT]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// reset release: asserted at once, released after two edges
	// logic below sees only mclk-aligned releases
	// a runt pulse on rst_b still clears it all
	logic [1:0] rst_sync; // bit 0 feeds bit 1 only
	logic rst_sync_b; // released reset used by all logic

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// state
	// config bytes, read answer, command, flags;
	// one struct, so one process owns each flop
	typedef struct packed {
		logic [7:0] stop_duty_and_keep_running_low_duty_cfg;
		logic [7:0] start_duty_cfg;
		logic [7:0] breakpoint_duty_cfg;
		logic [7:0] max_duty_cfg;
		logic [7:0] start_speed_high;
		logic [7:0] start_speed_low;
		logic [7:0] slope_one_high;
		logic [7:0] slope_one_low_and_flags;
		logic [7:0] slope_two_high;
		logic [7:0] slope_two_low;
		logic [7:0] speed_drop_limit_cfg;
		logic [7:0] rd_data; // read answer, held until the next read
		logic running; // low band memory: motor was above begin duty
		logic pass_state; // pass-through hysteresis memory
		logic [19:0] cmd_speed; // mapped target before the drop limiter
		logic closed_active; // registered copy for the output
		logic pass_active; // registered copy for the output
		logic [9:0] pass_duty; // registered copy for the output
	} clstm_state_t;

	clstm_state_t st_reg;
	clstm_state_t st_next;

	////////////////////////////////////////////////////////////////////////////////
	// decoded settings
	// every duty shares the 1/512 scale, so no
	// compare needs rescaling; top reaches 512
	logic [9:0] duty; // command in 1/512 units, zero extended
	logic [9:0] begin_duty_threshold;
	logic [9:0] halt_duty_threshold;
	logic [9:0] top_duty_threshold;
	logic [9:0] breakpoint_duty;
	logic breakpoint_used;
	logic [19:0] initial_speed_target;
	logic [13:0] first_gain;
	logic [13:0] second_gain;
	logic [3:0] top_duty_hysteresis;
	logic [9:0] pass_exit_duty; // duty below which pass-through ends
	logic keep_running_low_duty;
	logic zero_duty_to_full_speed;
	logic pass_through_above_max;
	logic speed_mode_select;
	logic [2:0] speed_drop_limit;
	logic [19:0] full_speed; // speed at top duty
	logic [19:0] curve_speed; // speed on the gain curve at the clamped duty
	logic [9:0] clamped_duty; // duty held at or below top; a duty below begin is not clamped
	logic [19:0] applied_speed; // limiter output

	// top bit zero: 511/512 is the highest command
	// command is nine bits wide
	assign duty = {1'b0, speed_command};

	always_comb begin
		// plain wiring of bytes into fields
		// threshold decode
		begin_duty_threshold = {2'b00, st_reg.start_duty_cfg};
		halt_duty_threshold = {2'b00, st_reg.stop_duty_and_keep_running_low_duty_cfg[6:0], 1'b0};
		top_duty_threshold = {2'b00, st_reg.max_duty_cfg} + CLSTM_TOP_DUTY_BIAS;
		breakpoint_duty = {1'b0, st_reg.breakpoint_duty_cfg, 1'b0};
		breakpoint_used = (st_reg.breakpoint_duty_cfg != 8'h00);
		initial_speed_target = {8'h00, st_reg.start_speed_high, st_reg.start_speed_low[7:4]};
		top_duty_hysteresis = st_reg.start_speed_low[3:0];
		first_gain = {st_reg.slope_one_high, st_reg.slope_one_low_and_flags[7:2]};
		second_gain = {st_reg.slope_two_high, st_reg.slope_two_low[7:2]};
		keep_running_low_duty = st_reg.stop_duty_and_keep_running_low_duty_cfg[CLSTM_KEEP_RUN_BIT];
		pass_through_above_max = st_reg.slope_one_low_and_flags[CLSTM_PASS_BIT];
		zero_duty_to_full_speed = st_reg.slope_one_low_and_flags[CLSTM_ZFULL_BIT];
		speed_mode_select = st_reg.slope_two_low[CLSTM_MODE_BIT];
		speed_drop_limit = st_reg.speed_drop_limit_cfg[CLSTM_DROP_MSB:CLSTM_DROP_LSB];
		// exit point sits (hysteresis + 1) * 2 steps below top duty
		// widened first: a setting of 15 gives 32 steps
		pass_exit_duty = clstm_sat_sub(top_duty_threshold,
			{4'h0, {1'b0, top_duty_hysteresis} + 5'h01, 1'b0});
	end

	////////////////////////////////////////////////////////////////////////////////
	// gain curve
	// duty above top is clamped: the curve flattens
	// both results are built, next state picks one
	always_comb begin
		clamped_duty = (duty > top_duty_threshold) ? top_duty_threshold : duty;
		// a misplaced breakpoint below begin duty only loses its first segment,
		// since the spans saturate instead of wrapping
		if (breakpoint_used && clamped_duty > breakpoint_duty) begin
			curve_speed = clstm_seg(clstm_seg(initial_speed_target, first_gain,
				clstm_sat_sub(breakpoint_duty, begin_duty_threshold)), second_gain,
				clstm_sat_sub(clamped_duty, breakpoint_duty));
		end else begin
			curve_speed = clstm_seg(initial_speed_target, first_gain,
				clstm_sat_sub(clamped_duty, begin_duty_threshold));
		end
		// recomputed every cycle, so a gain write needs
		// no stored copy to be refreshed
		// full speed derived from settings
		if (breakpoint_used && top_duty_threshold > breakpoint_duty) begin
			full_speed = clstm_seg(clstm_seg(initial_speed_target, first_gain,
				clstm_sat_sub(breakpoint_duty, begin_duty_threshold)), second_gain,
				clstm_sat_sub(top_duty_threshold, breakpoint_duty));
		end else begin
			full_speed = clstm_seg(initial_speed_target, first_gain,
				clstm_sat_sub(top_duty_threshold, begin_duty_threshold));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state: registers, hysteresis memories and target selection
	// one process, so a write, a read and a speed
	// update in one cycle cannot race each other
	always_comb begin
		st_next = st_reg;

		// register writes take effect at the strobe edge; unknown offsets are dropped
		// read-only and unknown offsets change nothing
		if (reg_req.wr) begin
			case (reg_req.addr)
				CLSTM_OFS_STOP: st_next.stop_duty_and_keep_running_low_duty_cfg = reg_req.wdata;
				CLSTM_OFS_START: st_next.start_duty_cfg = reg_req.wdata;
				CLSTM_OFS_BREAK: st_next.breakpoint_duty_cfg = reg_req.wdata;
				CLSTM_OFS_TOP: st_next.max_duty_cfg = reg_req.wdata;
				CLSTM_OFS_INIT_HI: st_next.start_speed_high = reg_req.wdata;
				CLSTM_OFS_INIT_LO: st_next.start_speed_low = reg_req.wdata;
				CLSTM_OFS_GAIN1_HI: st_next.slope_one_high = reg_req.wdata;
				CLSTM_OFS_GAIN1_LO: st_next.slope_one_low_and_flags = reg_req.wdata;
				CLSTM_OFS_GAIN2_HI: st_next.slope_two_high = reg_req.wdata;
				CLSTM_OFS_GAIN2_LO: st_next.slope_two_low = reg_req.wdata;
				CLSTM_OFS_DROP: st_next.speed_drop_limit_cfg = reg_req.wdata;
				default: st_next.rd_data = st_reg.rd_data;
			endcase
		end

		// reads capture the byte; unmapped offsets answer zero
		// the answer stands from the edge after the strobe
		if (reg_req.rd) begin
			case (reg_req.addr)
				CLSTM_OFS_STOP: st_next.rd_data = st_reg.stop_duty_and_keep_running_low_duty_cfg;
				CLSTM_OFS_START: st_next.rd_data = st_reg.start_duty_cfg;
				CLSTM_OFS_BREAK: st_next.rd_data = st_reg.breakpoint_duty_cfg;
				CLSTM_OFS_TOP: st_next.rd_data = st_reg.max_duty_cfg;
				CLSTM_OFS_INIT_HI: st_next.rd_data = st_reg.start_speed_high;
				CLSTM_OFS_INIT_LO: st_next.rd_data = st_reg.start_speed_low;
				CLSTM_OFS_GAIN1_HI: st_next.rd_data = st_reg.slope_one_high;
				CLSTM_OFS_GAIN1_LO: st_next.rd_data = st_reg.slope_one_low_and_flags;
				CLSTM_OFS_GAIN2_HI: st_next.rd_data = st_reg.slope_two_high;
				CLSTM_OFS_GAIN2_LO: st_next.rd_data = st_reg.slope_two_low;
				CLSTM_OFS_DROP: st_next.rd_data = st_reg.speed_drop_limit_cfg;
				CLSTM_OFS_TGT_HI: st_next.rd_data = {4'h0, applied_speed[19:16]};
				CLSTM_OFS_TGT_MID: st_next.rd_data = applied_speed[15:8];
				CLSTM_OFS_TGT_LO: st_next.rd_data = applied_speed[7:0];
				CLSTM_OFS_STATUS: st_next.rd_data = {5'h00, st_reg.running,
					st_reg.pass_active, st_reg.closed_active};
				default: st_next.rd_data = 8'h00;
			endcase
		end

		// between halt and begin the memory holds,
		// which gives the band its direction
		// low band memory follows direction
		if (duty > begin_duty_threshold) begin
			st_next.running = 1'b1;
		end else if (duty <= halt_duty_threshold) begin
			st_next.running = 1'b0;
		end

		// flag clear or open loop drops it at once;
		// the exit band stops chatter at top duty
		// pass-through entry and exit
		if (!pass_through_above_max || speed_mode_select) begin
			st_next.pass_state = 1'b0;
		end else if (duty >= top_duty_threshold) begin
			st_next.pass_state = 1'b1;
		end else if (duty < pass_exit_duty) begin
			st_next.pass_state = 1'b0;
		end

		// priority: mode, zero-duty flag, low band,
		// pass-through; the rest stays on the curve
		// default result: closed loop on the gain curve
		st_next.closed_active = 1'b1;
		st_next.pass_active = 1'b0;
		st_next.pass_duty = 10'h000;
		st_next.cmd_speed = curve_speed;

		if (speed_mode_select) begin
			st_next.closed_active = 1'b0;
			st_next.cmd_speed = CLSTM_SPEED_ZERO;
		end else if (zero_duty_to_full_speed && (duty == 10'h000 ||
			(keep_running_low_duty && duty <= halt_duty_threshold))) begin
			if (pass_through_above_max) begin
				st_next.closed_active = 1'b0;
				st_next.pass_active = 1'b1;
				st_next.pass_duty = CLSTM_FULL_DUTY;
			end
			// speed rides along, unused in pass mode
			st_next.cmd_speed = full_speed;
		end else if (duty <= begin_duty_threshold) begin
			if (keep_running_low_duty) begin
				st_next.cmd_speed = initial_speed_target;
			end else if (duty <= halt_duty_threshold) begin
				st_next.cmd_speed = CLSTM_SPEED_ZERO;
			end else begin
				st_next.cmd_speed = st_next.running ? initial_speed_target : CLSTM_SPEED_ZERO;
			end
		end else if (st_next.pass_state) begin
			// entry was decided above, same cycle
			// output duty equals input
			st_next.closed_active = 1'b0;
			st_next.pass_active = 1'b1;
			st_next.pass_duty = duty;
			st_next.cmd_speed = full_speed;
		end
		// each option decides its own band, the curve covers the rest
	end

	// register the state
	// all-zero config puts any nonzero duty on
	// the curve, so closed loop shows at once
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_reg <= '0;
			st_reg.stop_duty_and_keep_running_low_duty_cfg <= CLSTM_CFG_RESET;
			st_reg.start_duty_cfg <= CLSTM_CFG_RESET;
			st_reg.breakpoint_duty_cfg <= CLSTM_CFG_RESET;
			st_reg.max_duty_cfg <= CLSTM_CFG_RESET;
			st_reg.speed_drop_limit_cfg <= CLSTM_CFG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// drop limiter between the map and the regulator
	// fed from the registered command: one cycle
	// of latency keeps curve maths off its path
	// step chosen by the three-bit field
	clstm_drop_limiter #(
		.DROP_INTERVAL_CYCLES(DROP_INTERVAL_CYCLES)
	) u_drop_limiter (
		.mclk(mclk),
		.rst_sync_b(rst_sync_b),
		.cmd_speed(st_reg.cmd_speed),
		.bypass(!st_reg.closed_active),
		.step_sel(speed_drop_limit),
		.applied_speed(applied_speed)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	// in pass-through speed carries full speed
	assign reg_rd_data = st_reg.rd_data;
	assign target.speed = applied_speed;
	assign target.closed_active = st_reg.closed_active;
	assign target.pass_active = st_reg.pass_active;
	assign target.pass_duty = st_reg.pass_duty;

endmodule

// >>> pkg/clstm_pkg.sv
// shared constants, register map and carrier types of the closed-loop speed target map
package clstm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets on the byte register port
	localparam logic [7:0] CLSTM_OFS_STOP = 8'h02; // halt duty threshold, keep-running flag
	localparam logic [7:0] CLSTM_OFS_START = 8'h03; // begin duty threshold
	localparam logic [7:0] CLSTM_OFS_BREAK = 8'h04; // breakpoint duty
	localparam logic [7:0] CLSTM_OFS_TOP = 8'h05; // top duty threshold
	localparam logic [7:0] CLSTM_OFS_INIT_HI = 8'h06; // initial speed target [11:4]
	localparam logic [7:0] CLSTM_OFS_INIT_LO = 8'h07; // initial speed [3:0], top hysteresis
	localparam logic [7:0] CLSTM_OFS_GAIN1_HI = 8'h08; // first gain [13:6]
	localparam logic [7:0] CLSTM_OFS_GAIN1_LO = 8'h09; // first gain [5:0], two flags
	localparam logic [7:0] CLSTM_OFS_GAIN2_HI = 8'h0a; // second gain [13:6]
	localparam logic [7:0] CLSTM_OFS_GAIN2_LO = 8'h0b; // second gain [5:0], mode bit
	localparam logic [7:0] CLSTM_OFS_DROP = 8'h12; // speed drop limit select
	// read-only status of the block
	localparam logic [7:0] CLSTM_OFS_TGT_HI = 8'h30; // applied target [19:16]
	localparam logic [7:0] CLSTM_OFS_TGT_MID = 8'h31; // applied target [15:8]
	localparam logic [7:0] CLSTM_OFS_TGT_LO = 8'h32; // applied target [7:0]
	localparam logic [7:0] CLSTM_OFS_STATUS = 8'h33; // state flags

	////////////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam logic [7:0] CLSTM_CFG_RESET = 8'h00; // every config byte after reset
	localparam int CLSTM_KEEP_RUN_BIT = 7; // in stop register
	localparam int CLSTM_PASS_BIT = 1; // in first gain low register
	localparam int CLSTM_ZFULL_BIT = 0; // in first gain low register
	localparam int CLSTM_MODE_BIT = 0; // in second gain low register
	localparam int CLSTM_DROP_MSB = 7; // drop limit select field
	localparam int CLSTM_DROP_LSB = 5;
	localparam logic [9:0] CLSTM_TOP_DUTY_BIAS = 10'h101; // top duty = field + 257
	localparam logic [9:0] CLSTM_FULL_DUTY = 10'h200; // 100 percent duty in 1/512 units
	localparam int CLSTM_GAIN_SHIFT = 6; // gain lsb is 1/64 rpm per duty step
	localparam logic [19:0] CLSTM_SPEED_ZERO = 20'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// drop limit steps in rpm per update interval
	localparam logic [19:0] CLSTM_STEP_1 = 20'h00200; // 512
	localparam logic [19:0] CLSTM_STEP_2 = 20'h00898; // 2200
	localparam logic [19:0] CLSTM_STEP_3 = 20'h00ed8; // 3800
	localparam logic [19:0] CLSTM_STEP_4 = 20'h01518; // 5400
	localparam logic [19:0] CLSTM_STEP_5 = 20'h01b58; // 7000
	localparam logic [19:0] CLSTM_STEP_6 = 20'h02198; // 8600
	localparam logic [19:0] CLSTM_STEP_7 = 20'h02800; // 10240

	// update interval of the drop limiter
	localparam int CLSTM_CLK_PERIOD_NS = 10;
	localparam int CLSTM_DROP_INTERVAL_NS = 1000000;
	localparam int CLSTM_DROP_INTERVAL_CYCLES = CLSTM_DROP_INTERVAL_NS / CLSTM_CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// carrier types
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic rd; // one-cycle read strobe
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write byte
	} clstm_reg_req_t;

	typedef struct packed {
		logic [19:0] speed; // applied target in rpm
		logic closed_active; // closed-loop mapping in charge
		logic pass_active; // output duty follows input, or is full duty under the zero-duty flag, regulator bypassed
		logic [9:0] pass_duty; // output duty in 1/512 units when pass_active
	} clstm_target_t;

	// drop step for a select code, zero meaning unlimited
	function automatic logic [19:0] clstm_drop_step(input logic [2:0] sel);
		case (sel)
			3'h1: clstm_drop_step = CLSTM_STEP_1;
			3'h2: clstm_drop_step = CLSTM_STEP_2;
			3'h3: clstm_drop_step = CLSTM_STEP_3;
			3'h4: clstm_drop_step = CLSTM_STEP_4;
			3'h5: clstm_drop_step = CLSTM_STEP_5;
			3'h6: clstm_drop_step = CLSTM_STEP_6;
			3'h7: clstm_drop_step = CLSTM_STEP_7;
			default: clstm_drop_step = CLSTM_SPEED_ZERO;
		endcase
	endfunction

endpackage

// >>> hw/clstm_drop_limiter.sv
// limiter that lets the applied speed target fall only by a set step per interval
`timescale 1ns/1ns
module clstm_drop_limiter #(
	parameter int DROP_INTERVAL_CYCLES = clstm_pkg::CLSTM_DROP_INTERVAL_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_sync_b,
	input wire logic [19:0] cmd_speed,
	input wire logic bypass,
	input wire logic [2:0] step_sel,
	output logic [19:0] applied_speed
);
	import clstm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [19:0] cnt; // interval counter, wide enough for a 1 ms default
		logic [19:0] applied; // speed handed to the regulator
	} clstm_lim_state_t;

	clstm_lim_state_t st_reg;
	clstm_lim_state_t st_next;
	logic tick; // last cycle of an interval
	logic [19:0] step; // allowed fall this interval
	logic [19:0] floor_speed; // lowest value reachable this interval

	assign applied_speed = st_reg.applied;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_next = st_reg;
		step = clstm_drop_step(step_sel);
		tick = (st_reg.cnt == 20'(DROP_INTERVAL_CYCLES - 1));
		// free-running interval, so the pace does not depend on command timing
		st_next.cnt = tick ? 20'h00000 : st_reg.cnt + 20'h00001;
		// no underflow: a step larger than the target lands on zero
		floor_speed = (st_reg.applied > step) ? st_reg.applied - step : CLSTM_SPEED_ZERO;
		if (bypass || cmd_speed >= st_reg.applied || step == CLSTM_SPEED_ZERO) begin
			st_next.applied = cmd_speed;
		end else if (tick) begin
			st_next.applied = (cmd_speed > floor_speed) ? cmd_speed : floor_speed;
		end
	end

	// register the state
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

// >>> tb/clstm_target_map_props.sv
// port assertions of the closed-loop speed target map
`timescale 1ns/1ns
module clstm_target_map_props
	import clstm_pkg::*;
#(
	parameter int DROP_INTERVAL_CYCLES = 16
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire clstm_pkg::clstm_reg_req_t reg_req,
	input wire logic [7:0] reg_rd_data,
	input wire logic [8:0] speed_command,
	input wire clstm_pkg::clstm_target_t target
);
	////////////////////////////////////////////////////////////////////////////////
	logic [2:0] sel_reg; // drop select as seen on the bus
	logic mode_reg; // open-loop bit as seen on the bus
	// shadow of two config fields, only the bus can tell us them
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sel_reg <= 3'h0;
			mode_reg <= 1'b0;
		end else if (reg_req.wr && reg_req.addr == CLSTM_OFS_DROP) begin
			sel_reg <= reg_req.wdata[7:5];
		end else if (reg_req.wr && reg_req.addr == CLSTM_OFS_GAIN2_LO) begin
			mode_reg <= reg_req.wdata[0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	// write followed at once by a read of the same byte
	sequence s_wr_rd(logic [7:0] ofs);
		reg_req.wr && reg_req.addr == ofs ##1 reg_req.rd && reg_req.addr == ofs;
	endsequence
	property p_readback(logic [7:0] ofs);
		s_wr_rd(ofs) |=> reg_rd_data == $past(reg_req.wdata, 2);
	endproperty
	// open mode held long enough for the output registers to follow
	sequence s_mode_held;
		mode_reg [*4];
	endsequence
	a_start_readback: assert property (p_readback(CLSTM_OFS_START))
		else $error("begin duty byte readback wrong");
	a_break_readback: assert property (p_readback(CLSTM_OFS_BREAK))
		else $error("breakpoint byte readback wrong");
	a_init_readback: assert property (p_readback(CLSTM_OFS_INIT_HI))
		else $error("initial speed byte readback wrong");
	a_open_mode: assert property (s_mode_held |-> !target.closed_active && target.speed == 20'h0)
		else $error("map active in open-loop mode");
	a_pass_excl_closed: assert property (target.pass_active |-> !target.closed_active)
		else $error("pass-through and closed loop together");
	a_pass_duty_idle: assert property (!target.pass_active |-> target.pass_duty == 10'h000)
		else $error("pass duty not zero while idle");
	a_pass_follows: assert property (target.pass_active && target.pass_duty != CLSTM_FULL_DUTY &&
		$past(speed_command) == $past(speed_command, 2) |-> target.pass_duty == {1'b0, $past(speed_command)})
		else $error("pass duty does not follow command");
	// with the 512 step a closed-loop fall never exceeds 512 in one cycle
	a_drop_bound: assert property (sel_reg == 3'h1 && $past(sel_reg) == 3'h1 && target.closed_active &&
		$past(target.closed_active) |-> {1'b0, target.speed} + 21'd512 >= {1'b0, $past(target.speed)})
		else $error("speed fell by more than the step");
endmodule

bind clstm_target_map clstm_target_map_props #(.DROP_INTERVAL_CYCLES(DROP_INTERVAL_CYCLES)) u_props (
	.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
	.speed_command(speed_command), .target(target));

// >>> tb/clstm_cmd_source.sv
// speed command source: resolves a requested duty into the 9-bit command
`timescale 1ns/1ns
module clstm_cmd_source (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [8:0] duty_req,
	output logic [8:0] speed_command
);
	// nine-bit duty command
	// registered like a capture stage, so the command moves one cycle late
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			speed_command <= 9'h000;
		end else begin
			speed_command <= duty_req;
		end
	end
endmodule

// >>> tb/tb_clstm_target_map.sv
// self-checking bench of the closed-loop speed target map
`timescale 1ns/1ns
module tb_clstm_target_map;
	import clstm_pkg::*;
	localparam int DROP_CYC = 16; // short limiter interval keeps the run brief
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	clstm_reg_req_t reg_req = '0;
	logic [7:0] reg_rd_data;
	logic [8:0] duty_req = 9'h000;
	logic [8:0] speed_command;
	clstm_target_t target;
	int num_errors = 0;
	int num_checks = 0;
	always #5 mclk = ~mclk;
	clstm_cmd_source clstm_cmd_source_i (.mclk(mclk), .rst_b(rst_b), .duty_req(duty_req),
		.speed_command(speed_command));
	clstm_target_map #(.DROP_INTERVAL_CYCLES(DROP_CYC)) clstm_target_map_i (.mclk(mclk),
		.rst_b(rst_b), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
		.speed_command(speed_command), .target(target));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one request cycle; the leading edge keeps two requests from sharing a time step
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_req = '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge mclk);
		#1;
		reg_req = '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, 1'b1, a, 8'h00);
		check("reg_rd_data", {12'h000, exp}, {12'h000, reg_rd_data});
	endtask
	// write, then read the same byte on the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		#1;
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		#1;
		reg_req = '0;
		check("readback", {12'h000, d}, {12'h000, reg_rd_data});
	endtask
	// bounded poll; a limited fall may need a whole interval
	task automatic wait_speed(input logic [19:0] exp, input int lim);
		int n;
		n = 0;
		while (target.speed !== exp && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("speed", exp, target.speed);
	endtask
	// source stage plus the two cycles of the speed path
	task automatic duty_speed(input logic [8:0] d, input logic [19:0] exp, input int lim);
		duty_req = d;
		repeat (3) @(posedge mclk);
		#1;
		wait_speed(exp, lim);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		rd_chk(CLSTM_OFS_START, CLSTM_CFG_RESET);
		rd_chk(CLSTM_OFS_DROP, CLSTM_CFG_RESET);
		rd_chk(8'h40, 8'h00);
		// begin 102, halt 92, top 461, initial 1500, gain one rpm a step
		wr_rd(CLSTM_OFS_START, 8'h66);
		wr(CLSTM_OFS_STOP, 8'h2e);
		wr(CLSTM_OFS_TOP, 8'hcc);
		wr_rd(CLSTM_OFS_INIT_HI, 8'h5d);
		wr(CLSTM_OFS_INIT_LO, 8'hc0);
		wr(CLSTM_OFS_GAIN1_HI, 8'h01);
		duty_speed(9'd200, 20'd1598, 40);
		rd_chk(CLSTM_OFS_TGT_LO, 8'h3e);
		rd_chk(CLSTM_OFS_STATUS, 8'h05);
		duty_speed(9'd500, 20'd1859, 40);
		duty_speed(9'd95, 20'd1500, 40);
		duty_speed(9'd60, 20'd0, 40);
		duty_speed(9'd95, 20'd0, 40);
		duty_speed(9'd0, 20'd0, 40);
		wr(CLSTM_OFS_STOP, 8'hae);
		duty_speed(9'd0, 20'd1500, 40);
		duty_speed(9'd60, 20'd1500, 40);
		wr(CLSTM_OFS_GAIN1_LO, 8'h01);
		duty_speed(9'd0, 20'd1859, 40);
		duty_speed(9'd60, 20'd1859, 40);
		duty_speed(9'd96, 20'd1500, 40);
		wr(CLSTM_OFS_GAIN1_LO, 8'h03);
		duty_speed(9'd0, 20'd1859, 40);
		check("pass_duty", 20'd512, {10'h000, target.pass_duty});
		check("closed_active", 20'h0, {19'h0, target.closed_active});
		duty_speed(9'd470, 20'd1859, 40);
		check("pass_duty", 20'd470, {10'h000, target.pass_duty});
		check("pass_active", 20'h1, {19'h0, target.pass_active});
		wr(CLSTM_OFS_INIT_LO, 8'hcf);
		duty_speed(9'd440, 20'd1859, 40);
		check("pass_duty", 20'd440, {10'h000, target.pass_duty});
		duty_speed(9'd420, 20'd1818, 40);
		check("pass_active", 20'h0, {19'h0, target.pass_active});
		wr(CLSTM_OFS_GAIN1_LO, 8'h00);
		wr(CLSTM_OFS_STOP, 8'h2e);
		// breakpoint at 256 with a second gain of 128
		wr(CLSTM_OFS_GAIN2_HI, 8'h02);
		// breakpoint kept between begin and top
		wr_rd(CLSTM_OFS_BREAK, 8'h80);
		duty_speed(9'd300, 20'd1742, 40);
		wr(CLSTM_OFS_GAIN1_LO, 8'h01);
		duty_speed(9'd0, 20'd2064, 40);
		wr(CLSTM_OFS_GAIN1_LO, 8'h00);
		wr(CLSTM_OFS_BREAK, 8'h00);
		duty_speed(9'd300, 20'd1698, 40);
		wr(CLSTM_OFS_GAIN2_LO, 8'h01);
		duty_speed(9'd300, 20'd0, 40);
		check("closed_active", 20'h0, {19'h0, target.closed_active});
		wr(CLSTM_OFS_GAIN2_LO, 8'h00);
		// 512 step: rises are immediate, falls go one step an interval
		wr(CLSTM_OFS_DROP, 8'h20);
		duty_speed(9'd500, 20'd1859, 0);
		duty_speed(9'd60, 20'd1347, 40);
		wait_speed(20'd835, 40);
		wait_speed(20'd323, 40);
		wait_speed(20'd0, 40);
		summarize();
	end
endmodule
